// >>> design/usp_top.sv
// Notes on behaviour
// - Characters are always eight data bits.
// - Parity none, odd or even, shared by transmit and receive.
// - Every frame ends with exactly one stop bit.
// - Programmable baud rate, 9600 after reset, 9600 to 115200 covered.
// - Both partners must use identical frame settings.
// - With no external pins selected, lines go to the USB converter.
// - External routing detaches converter; clearing selection restores it.
// - Status shows true while a received byte waits.
// - Reads return at most what is waiting; timeout flagged if none.
// - Character timeout in ms is 13000 divided by baud, plus one.
// - Sixty-four byte receive buffer; overflowing bytes may be lost.
// - Received 0x03 raises a switchable break event.
// - Buffer fill: software counts bytes taken, timeout flag ends it.
// - Line reads end at newline; newline seen flag, else timeout.
// - Transmit reports done per byte, with count kept by software.
`timescale 1ns/100ps
`include "usp_map.svh"
module usp_top #(
    parameter int DEPTH  = 64,
    parameter int CLK_HZ = `USP_CLK_HZ
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Serial lines: converter side and external pins
    output usp_pkg::usp_line_t usb_out,
    input  wire logic        usb_rxd,
    output logic             ext_txd,
    input  wire logic        ext_rxd,
    // Interrupt and console state
    output logic             irq,
    output logic             console_on
);
    localparam int AW = $clog2(DEPTH);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [31:0] ctrl;
    logic [31:0] baud;
    logic [5:0]  events;
    logic [5:0]  mask;
    logic [31:0] bit_div;
    logic [31:0] tmo_cycles;
    usp_pkg::usp_par_t par;
    assign par = usp_pkg::usp_par_t'(ctrl[1:0]);
    wire ext_sel = ctrl[`USP_CTRL_EXT];
    wire brk_en  = ctrl[`USP_CTRL_BRK_EN];
    // ----------------------------------------------------------------
    // Bus handshake: write taken when address and data are both held
    // ----------------------------------------------------------------
    logic aw_hold;
    logic w_hold;
    logic [7:0]  aw_q;
    logic [31:0] w_q;
    wire do_wr = aw_hold && w_hold && !s_axi_bvalid;
    wire do_rd = s_axi_arvalid && s_axi_arready;
    wire [7:0] rd_a = s_axi_araddr;
    wire wr_ctrl = do_wr && aw_q == `USP_OFF_CTRL;
    wire wr_baud = do_wr && aw_q == `USP_OFF_BAUD;
    wire wr_tx   = do_wr && aw_q == `USP_OFF_TXDATA;
    wire wr_mask = do_wr && aw_q == `USP_OFF_MASK;
    wire wr_map  = wr_ctrl || wr_baud || wr_tx || wr_mask;
    wire rd_rx   = do_rd && rd_a == `USP_OFF_RXDATA;
    wire rd_ev   = do_rd && rd_a == `USP_OFF_EVENT;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            aw_q    <= 8'h00;
            w_q     <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_q    <= s_axi_awaddr;
            end else if (do_wr) begin
                aw_hold <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_q    <= s_axi_wdata;
            end else if (do_wr) begin
                w_hold <= 1'b0;
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `USP_AXI_OKAY;
        end else begin
            s_axi_awready <= !aw_hold && !(s_axi_awvalid && s_axi_awready)
                             && !s_axi_bvalid;
            s_axi_wready  <= !w_hold && !(s_axi_wvalid && s_axi_wready)
                             && !s_axi_bvalid;
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? `USP_AXI_OKAY : `USP_AXI_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // ----------------------------------------------------------------
    // Config registers; a baud write of zero is ignored, keeping the old divider
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl    <= `USP_CTRL_RESET;
            baud    <= `USP_BAUD_RESET;
            mask    <= 6'h00;
            bit_div <= CLK_HZ / 9600;
            tmo_cycles <= (`USP_TMO_NUM / 9600 + 1) * (CLK_HZ / 1000);
        end else begin
            if (wr_ctrl)
                ctrl <= {28'h0000000, w_q[3:0]};
            if (wr_mask)
                mask <= w_q[5:0];
            if (wr_baud && w_q != 32'h0000_0000) begin
                baud    <= w_q;
                bit_div <= CLK_HZ / w_q;
                tmo_cycles <= (`USP_TMO_NUM / w_q + 1) * (CLK_HZ / 1000);
            end
        end
    end
    // ----------------------------------------------------------------
    // Line routing and input synchroniser
    // ----------------------------------------------------------------
    logic txd;
    logic rx_s1;
    logic rx_s2;
    wire  rx_pin = ext_sel ? ext_rxd : usb_rxd;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rx_s1      <= 1'b1;
            rx_s2      <= 1'b1;
            usb_out    <= '{txd: 1'b1, rxd: 1'b1};
            ext_txd    <= 1'b1;
            console_on <= 1'b1;
        end else begin
            rx_s1      <= rx_pin;
            rx_s2      <= rx_s1;
            usb_out.txd <= ext_sel ? 1'b1 : txd;
            usb_out.rxd <= 1'b1;
            ext_txd    <= ext_sel ? txd : 1'b1;
            console_on <= !ext_sel;
        end
    end
    // ----------------------------------------------------------------
    // Transmitter
    // ----------------------------------------------------------------
    usp_pkg::usp_state_t tx_st;
    logic [7:0]  tx_sh;
    logic [2:0]  tx_bit;
    logic [31:0] tx_cnt;
    logic        tx_par;
    logic        tx_busy;
    wire tx_tick = tx_cnt >= bit_div - 32'd1;
    wire tx_go   = wr_tx && !tx_busy;
    wire tx_done = tx_st == usp_pkg::USP_STOP && tx_tick;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_st   <= usp_pkg::USP_IDLE;
            tx_sh   <= 8'h00;
            tx_bit  <= 3'h0;
            tx_cnt  <= 32'h0000_0000;
            tx_par  <= 1'b0;
            txd     <= 1'b1;
            tx_busy <= 1'b0;
        end else begin
            tx_cnt <= (tx_st == usp_pkg::USP_IDLE || tx_tick)
                      ? 32'h0000_0000 : tx_cnt + 32'd1;
            case (tx_st)
                usp_pkg::USP_IDLE: begin
                    txd <= 1'b1;
                    if (tx_go) begin
                        tx_sh   <= w_q[7:0];
                        tx_par  <= (par == usp_pkg::USP_PAR_ODD) ^ ^w_q[7:0];
                        tx_busy <= 1'b1;
                        txd     <= 1'b0;
                        tx_st   <= usp_pkg::USP_START;
                    end
                end
                usp_pkg::USP_START: if (tx_tick) begin
                    txd    <= tx_sh[0];
                    tx_bit <= 3'h0;
                    tx_st  <= usp_pkg::USP_DATA;
                end
                usp_pkg::USP_DATA: if (tx_tick) begin
                    tx_sh  <= {1'b0, tx_sh[7:1]};
                    tx_bit <= tx_bit + 3'h1;
                    txd    <= tx_sh[1];
                    if (tx_bit == 3'h7) begin
                        txd   <= (par == usp_pkg::USP_PAR_NONE) ? 1'b1 : tx_par;
                        tx_st <= (par == usp_pkg::USP_PAR_NONE)
                                 ? usp_pkg::USP_STOP : usp_pkg::USP_PARITY;
                    end
                end
                usp_pkg::USP_PARITY: if (tx_tick) begin
                    txd   <= 1'b1;
                    tx_st <= usp_pkg::USP_STOP;
                end
                usp_pkg::USP_STOP: if (tx_tick) begin
                    tx_busy <= 1'b0;
                    tx_st   <= usp_pkg::USP_IDLE;
                end
                default: tx_st <= usp_pkg::USP_IDLE;
            endcase
        end
    end
    // ----------------------------------------------------------------
    // Receiver: samples each bit at its middle
    // ----------------------------------------------------------------
    usp_pkg::usp_state_t rx_st;
    logic [7:0]  rx_sh;
    logic [2:0]  rx_bit;
    logic [31:0] rx_cnt;
    wire rx_tick = rx_cnt >= bit_div - 32'd1;
    wire rx_half = rx_cnt >= {1'b0, bit_div[31:1]};
    logic        rx_push;
    logic        rx_perr;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rx_st   <= usp_pkg::USP_IDLE;
            rx_sh   <= 8'h00;
            rx_bit  <= 3'h0;
            rx_cnt  <= 32'h0000_0000;
            rx_push <= 1'b0;
            rx_perr <= 1'b0;
        end else begin
            rx_push <= 1'b0;
            rx_perr <= 1'b0;
            rx_cnt  <= rx_tick ? 32'h0000_0000 : rx_cnt + 32'd1;
            case (rx_st)
                usp_pkg::USP_IDLE: begin
                    rx_cnt <= 32'h0000_0000;
                    if (!rx_s2)
                        rx_st <= usp_pkg::USP_START;
                end
                usp_pkg::USP_START: if (rx_half) begin
                    rx_cnt <= 32'h0000_0000;
                    rx_bit <= 3'h0;
                    rx_st  <= rx_s2 ? usp_pkg::USP_IDLE : usp_pkg::USP_DATA;
                end
                usp_pkg::USP_DATA: if (rx_tick) begin
                    rx_sh  <= {rx_s2, rx_sh[7:1]};
                    rx_bit <= rx_bit + 3'h1;
                    if (rx_bit == 3'h7)
                        rx_st <= (par == usp_pkg::USP_PAR_NONE)
                                 ? usp_pkg::USP_STOP : usp_pkg::USP_PARITY;
                end
                usp_pkg::USP_PARITY: if (rx_tick) begin
                    rx_perr <= (^rx_sh ^ rx_s2) != (par == usp_pkg::USP_PAR_ODD);
                    rx_st   <= usp_pkg::USP_STOP;
                end
                usp_pkg::USP_STOP: if (rx_tick) begin
                    rx_push <= rx_s2;
                    rx_st   <= usp_pkg::USP_IDLE;
                end
                default: rx_st <= usp_pkg::USP_IDLE;
            endcase
        end
    end
    // ----------------------------------------------------------------
    // Receive buffer, flip-flop storage
    // ----------------------------------------------------------------
    logic [7:0]  mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   level;
    wire full   = level == (AW+1)'(DEPTH);
    wire empty  = level == '0;
    wire push   = rx_push && !full;
    wire pop    = rd_rx && !empty;
    wire brk    = rx_push && brk_en && rx_sh == `USP_BREAK_CHAR;
    always_ff @(posedge core_clk) begin
        if (push)
            mem[wp] <= rx_sh;
    end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wp    <= '0;
            rp    <= '0;
            level <= '0;
        end else begin
            if (push)
                wp <= wp + 1'b1;
            if (pop)
                rp <= rp + 1'b1;
            level <= level + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    // ----------------------------------------------------------------
    // Character timeout, restarted by every received byte or RXDATA read
    // ----------------------------------------------------------------
    logic [31:0] tmo_cnt;
    wire tmo_hit = empty && tmo_cnt == tmo_cycles;
    always_ff @(posedge core_clk) begin
        if (reset || rx_push || do_rd && rd_a == `USP_OFF_RXDATA)
            tmo_cnt <= 32'h0000_0000;
        else if (tmo_cnt != tmo_cycles)
            tmo_cnt <= tmo_cnt + 32'd1;
    end
    // ----------------------------------------------------------------
    // Sticky events: set wins over read clear
    // ----------------------------------------------------------------
    wire [5:0] ev_set = {tx_done, rx_perr, tmo_hit && tmo_cnt != 32'h0,
                         brk, rx_push && full, push};
    logic       nl_seen;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            events  <= 6'h00;
            irq     <= 1'b0;
            nl_seen <= 1'b0;
        end else begin
            events  <= (rd_ev ? 6'h00 : events) | ev_set;
            irq     <= |(((rd_ev ? 6'h00 : events) | ev_set) & mask);
            if (push && rx_sh == `USP_NEWLINE)
                nl_seen <= 1'b1;
            else if (pop && mem[rp] == `USP_NEWLINE)
                nl_seen <= 1'b0;
        end
    end
    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    wire [31:0] status_w = {24'h000000, 1'b0, nl_seen, tx_busy, full,
                            tmo_hit, 2'b00, !empty};
    wire [31:0] rx_word = empty ? 32'h0000_0100
                                : {24'h000000, mem[rp]};
    logic [31:0] rd_mux;
    logic        rd_ok;
    always_comb begin
        rd_ok  = 1'b1;
        case (rd_a)
            `USP_OFF_CTRL:   rd_mux = ctrl;
            `USP_OFF_BAUD:   rd_mux = baud;
            `USP_OFF_STATUS: rd_mux = status_w;
            `USP_OFF_RXDATA: rd_mux = rx_word;
            `USP_OFF_EVENT:  rd_mux = {26'h0000000, events};
            `USP_OFF_MASK:   rd_mux = {26'h0000000, mask};
            `USP_OFF_LEVEL:  rd_mux = 32'(level);
            default: begin
                rd_mux = 32'h0000_0000;
                rd_ok  = 1'b0;
            end
        endcase
    end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `USP_AXI_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !do_rd;
            if (do_rd) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_ok ? `USP_AXI_OKAY : `USP_AXI_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // usp_top

// >>> inc/usp_map.svh
`ifndef USP_MAP_SVH
`define USP_MAP_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define USP_OFF_CTRL     8'h00
`define USP_OFF_BAUD     8'h04
`define USP_OFF_STATUS   8'h08
`define USP_OFF_RXDATA   8'h0C
`define USP_OFF_TXDATA   8'h10
`define USP_OFF_EVENT    8'h14
`define USP_OFF_MASK     8'h18
`define USP_OFF_LEVEL    8'h1C
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define USP_CTRL_PAR_LO  0
`define USP_CTRL_EXT     2
`define USP_CTRL_BRK_EN  3
`define USP_CTRL_RESET   32'h0000_0008
`define USP_BAUD_RESET   32'h0000_2580
`define USP_EV_RXAVAIL   0
`define USP_EV_OVERRUN   1
`define USP_EV_BREAK     2
`define USP_EV_TIMEOUT   3
`define USP_EV_PARERR    4
`define USP_EV_TXDONE    5
`define USP_BREAK_CHAR   8'h03
`define USP_NEWLINE      8'h0A
`define USP_TMO_NUM      13000
`define USP_CLK_HZ       25000000
`define USP_AXI_OKAY     2'h0
`define USP_AXI_SLVERR   2'h2
`endif

// >>> inc/usp_pkg.sv
package usp_pkg;
    typedef enum logic [1:0] {
        USP_PAR_NONE = 2'h0,
        USP_PAR_ODD  = 2'h1,
        USP_PAR_EVEN = 2'h2
    } usp_par_t;
    typedef enum logic [2:0] {
        USP_IDLE   = 3'h0,
        USP_START  = 3'h1,
        USP_DATA   = 3'h3,
        USP_PARITY = 3'h2,
        USP_STOP   = 3'h6
    } usp_state_t;
    typedef struct packed {
        logic       txd;
        logic       rxd;
    } usp_line_t;
endpackage

// >>> verif/usp_chk.sv
`timescale 1ns/100ps
module usp_chk #(
    parameter int DEPTH  = 64,
    parameter int CLK_HZ = 25000000
) (
    // Clock and reset
    input wire logic               core_clk,
    input wire logic               reset,
    // Bus handshakes
    input wire logic               s_axi_awvalid,
    input wire logic               s_axi_awready,
    input wire logic               s_axi_wvalid,
    input wire logic               s_axi_wready,
    input wire logic [1:0]         s_axi_bresp,
    input wire logic               s_axi_bvalid,
    input wire logic               s_axi_bready,
    input wire logic               s_axi_arvalid,
    input wire logic               s_axi_arready,
    input wire logic               s_axi_rvalid,
    input wire logic               s_axi_rready,
    // Serial lines and state
    input wire usp_pkg::usp_line_t usb_out,
    input wire logic               ext_txd,
    input wire logic               irq,
    input wire logic               console_on
);
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_tx_low;
        !usb_out.txd [*8];
    endsequence
    a_wr_answer: assert property (s_wr_both |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read data not one cycle after address");
    a_busy_ready: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("ready while busy");
    a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid) else $error("write response repeated");
    a_r_drop: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid ##1 s_axi_arready) else $error("read not finished");
    a_resp_code: assert property (s_axi_bvalid |->
        s_axi_bresp inside {2'h0, 2'h2}) else $error("bad response code");
    a_reset_state: assert property ($fell(reset) |-> console_on && !irq
        && usb_out.txd && !s_axi_bvalid) else $error("bad state at reset");
    a_ext_quiet: assert property (console_on && $stable(console_on) |->
        ext_txd) else $error("pins driven on console route");
    a_usb_quiet: assert property (!console_on && $stable(console_on) |->
        usb_out.txd) else $error("converter driven on pin route");
    a_start_width: assert property ($fell(usb_out.txd) |-> s_tx_low)
        else $error("start bit too short");
    a_bit_width: assert property ($rose(usb_out.txd) |->
        usb_out.txd [*8]) else $error("high bit too short");
endmodule // usp_chk
bind usp_top usp_chk #(.DEPTH(DEPTH), .CLK_HZ(CLK_HZ)) chk_u (
    .core_clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .usb_out, .ext_txd, .irq, .console_on);

// >>> verif/usp_peer.sv
`timescale 1ns/100ps
module usp_peer (
    // Clock
    input  wire logic core_clk,
    // Serial lines seen from the far side
    input  wire logic line_in,
    output logic      line_out
);
    // ----------------------------------------------------------------
    // Far-side serial device
    // ----------------------------------------------------------------
    // Bench keeps this equal to the port's bit time
    int bit_cyc = 120;
    initial line_out = 1'b1;
    task automatic send(input logic [7:0] v, input logic [1:0] par,
                        input logic bad);
        logic [10:0] f;
        int          n;
        f = {1'b1, (par == 2'h0) | (^v ^ (par == 2'h1) ^ bad), v, 1'b0};
        n = (par == 2'h0) ? 10 : 11;
        for (int k = 0; k < n; k++) begin
            line_out <= f[k];
            repeat (bit_cyc) @(posedge core_clk);
        end
    endtask
    // Samples mid-bit, so a slow edge still decodes
    task automatic recv(input logic [1:0] par, output logic [7:0] v,
                        output logic ok);
        int k;
        k = 0;
        while (line_in !== 1'b0 && k < 5000) begin
            @(posedge core_clk);
            k++;
        end
        repeat (bit_cyc / 2) @(posedge core_clk);
        ok = (line_in === 1'b0);
        for (k = 0; k < 8; k++) begin
            repeat (bit_cyc) @(posedge core_clk);
            v[k] = line_in;
        end
        if (par != 2'h0) begin
            repeat (bit_cyc) @(posedge core_clk);
            ok &= (line_in === (^v ^ (par == 2'h1)));
        end
        repeat (bit_cyc) @(posedge core_clk);
        ok &= (line_in === 1'b1);
    endtask
endmodule // usp_peer

// >>> verif/usp_top_bench.sv
`timescale 1ns/100ps
`include "usp_map.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module usp_top_bench;
    logic               core_clk, reset, ext, peer_tx, peer_rx, ok;
    logic [7:0]         s_axi_awaddr, s_axi_araddr, b;
    logic [31:0]        s_axi_wdata, s_axi_rdata, d;
    logic [3:0]         s_axi_wstrb;
    logic [1:0]         s_axi_bresp, s_axi_rresp;
    logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic               s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic               s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic               s_axi_rready, usb_rxd, ext_txd, ext_rxd, irq;
    logic               console_on;
    usp_pkg::usp_line_t usb_out;
    int                 miscompares = 0, cmp_count = 0, i;
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Unselected receive input idles high like an open line
    assign usb_rxd = ext ? 1'b1 : peer_tx;
    assign ext_rxd = ext ? peer_tx : 1'b1;
    assign peer_rx = ext ? ext_txd : usb_out.txd;
    // Small clock rate: 10 cycles a bit at 115200, 1152 cycles a ms
    usp_top #(.DEPTH(64), .CLK_HZ(1152000)) dut_u (
        .core_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .usb_out, .usb_rxd, .ext_txd,
        .ext_rxd, .irq, .console_on);
    usp_peer peer_u (.core_clk, .line_in(peer_rx), .line_out(peer_tx));
    // ----------------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      input logic [1:0] er = `USP_AXI_OKAY);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        `CHK({s_axi_bvalid, s_axi_bresp}, {1'b1, er})
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      input logic [1:0] er = `USP_AXI_OKAY);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        v = s_axi_rdata;
        `CHK({s_axi_rvalid, s_axi_rresp}, {1'b1, er})
    endtask
    task automatic rx(input logic [7:0] v, input logic [1:0] p,
                      input logic bad = 1'b0);
        peer_u.send(v, p, bad);
        repeat (20) @(posedge core_clk);
    endtask
    task automatic tx(input logic [7:0] v, input logic [1:0] p);
        fork
            peer_u.recv(p, b, ok);
            wr(`USP_OFF_TXDATA, {24'h0, v});
        join
        `CHK({ok, b}, {1'b1, v})
    endtask
    task automatic drain;
        for (int n = 0; n < 70; n++) begin
            rd(`USP_OFF_RXDATA, d);
            if (d[8]) break;
        end
    endtask
    task automatic results;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge core_clk);
        miscompares++;
        results;
    end
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        {reset, ext, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = {2'h2, 48'h0};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h1;
        {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h1F;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        repeat (2) @(posedge core_clk);
        rd(`USP_OFF_CTRL, d);
        `CHK(d, `USP_CTRL_RESET)
        rd(`USP_OFF_BAUD, d);
        `CHK(d, `USP_BAUD_RESET)
        `CHK(console_on, 1'b1)
        for (i = 0; i < 3; i++) begin
            wr(`USP_OFF_CTRL, 32'h8 | i);
            tx(8'hA5 ^ i[7:0], i[1:0]);
            rx(8'h3C + i[7:0], i[1:0]);
            rd(`USP_OFF_RXDATA, d);
            `CHK(d[8:0], {1'b0, 8'h3C + i[7:0]})
            if (i == 0) begin
                wr(`USP_OFF_BAUD, 32'h0001_C200);
                peer_u.bit_cyc = 10;
            end
        end
        rd(`USP_OFF_EVENT, d);
        `CHK({d[5], d[0]}, 2'h3)
        rx(8'h55, 2'h2, 1'b1);
        rd(`USP_OFF_EVENT, d);
        `CHK(d[4], 1'b1)
        drain;
        wr(`USP_OFF_BAUD, 32'h0);
        rd(`USP_OFF_BAUD, d);
        `CHK(d, 32'h0001_C200)
        wr(`USP_OFF_CTRL, 32'hC);
        ext <= 1'b1;
        repeat (2) @(posedge core_clk);
        `CHK(console_on, 1'b0)
        tx(8'h81, 2'h0);
        rx(8'h7E, 2'h0);
        rd(`USP_OFF_RXDATA, d);
        `CHK(d[8:0], 9'h07E)
        wr(`USP_OFF_CTRL, 32'h8);
        ext <= 1'b0;
        repeat (2) @(posedge core_clk);
        `CHK(console_on, 1'b1)
        wr(`USP_OFF_MASK, 32'h4);
        rd(`USP_OFF_EVENT, d);
        rx(`USP_BREAK_CHAR, 2'h0);
        `CHK(irq, 1'b1)
        rd(`USP_OFF_EVENT, d);
        `CHK(d[2], 1'b1)
        repeat (2) @(posedge core_clk);
        `CHK(irq, 1'b0)
        wr(`USP_OFF_CTRL, 32'h0);
        rx(`USP_BREAK_CHAR, 2'h0);
        rd(`USP_OFF_EVENT, d);
        `CHK({d[2], irq}, 2'h0)
        drain;
        rx(`USP_NEWLINE, 2'h0);
        rd(`USP_OFF_STATUS, d);
        `CHK({d[6], d[0]}, 2'h3)
        drain;
        rd(`USP_OFF_STATUS, d);
        `CHK({d[6], d[0]}, 2'h0)
        for (i = 0; i < 65; i++) rx(i[7:0], 2'h0);
        rd(`USP_OFF_LEVEL, d);
        `CHK(d, 32'h40)
        rd(`USP_OFF_STATUS, d);
        `CHK(d[4], 1'b1)
        rd(`USP_OFF_EVENT, d);
        `CHK(d[1], 1'b1)
        rd(`USP_OFF_RXDATA, d);
        `CHK(d[8:0], 9'h000)
        drain;
        rd(`USP_OFF_EVENT, d);
        repeat (1000) @(posedge core_clk);
        rd(`USP_OFF_EVENT, d);
        `CHK(d[3], 1'b0)
        repeat (300) @(posedge core_clk);
        rd(`USP_OFF_EVENT, d);
        `CHK(d[3], 1'b1)
        wr(8'h20, 32'h1, `USP_AXI_SLVERR);
        rd(8'h20, d, `USP_AXI_SLVERR);
        results;
    end
endmodule // usp_top_bench
